/* File: dv/adc_ctrl_assertions.sv */
// adc_ctrl_assertions.sv: bus and converter checks on the adc_ctrl ports
// assumes a classic wishbone master with one idle cycle between requests
`default_nettype none
`include "adc_ctrl_params.svh"
module adc_ctrl_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // front end and interrupt
    input wire logic cmp_i,
    input wire logic [9:0] dac_o,
    input wire logic [1:0] chan_sel_o,
    input wire logic cmp_power_o,
    input wire logic conversion_end_irq_o
);
    logic take, wr_ok, wr_mode, wr_chan, wr_mask;
    assign take = cyc_i && stb_i && !ack_o;
    assign wr_ok = take && we_i && sel_i[0];
    assign wr_mode = wr_ok && adr_i == `OFS_MODE;
    assign wr_chan = wr_ok && adr_i == `OFS_CHAN;
    assign wr_mask = wr_ok && adr_i == `OFS_MASK;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held");
    ack_lat_a: assert property (take |=> ack_o) else $error("ack missing");
    ack_idle_a: assert property (!take |=> !ack_o) else $error("stray ack");
    chan_load_a: assert property (wr_chan |=> chan_sel_o == $past(dat_i[1:0]))
        else $error("channel not loaded");
    chan_hold_a: assert property (!wr_chan |=> $stable(chan_sel_o))
        else $error("channel moved");
    irq_keep_a: assert property (wr_chan |=> !$fell(conversion_end_irq_o))
        else $error("channel write cleared flag");
    irq_quiet_a: assert property (wr_mode || wr_chan |=> !$rose(conversion_end_irq_o))
        else $error("irq beside register write");
    wait_power_a: assert property (wr_mode |=> ##1
        cmp_power_o == ($past(dat_i[7], 2) | $past(dat_i[0], 2)))
        else $error("comparator power wrong");
    mask_off_a: assert property (wr_mask && dat_i[1:0] == 2'h0 |=> !conversion_end_irq_o)
        else $error("masked irq high");
    dac_idle_a: assert property (!cmp_power_o |=> dac_o == 10'h200)
        else $error("dac not parked");
    cover property (wr_mode ##2 cmp_power_o);
    cover property (conversion_end_irq_o ##1 wr_chan);
    cover property ($rose(conversion_end_irq_o));
endmodule // adc_ctrl_checker
bind adc_ctrl adc_ctrl_checker u_adc_ctrl_checker (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cmp_i(cmp_i), .dac_o(dac_o),
    .chan_sel_o(chan_sel_o), .cmp_power_o(cmp_power_o),
    .conversion_end_irq_o(conversion_end_irq_o));
`default_nettype wire

/* File: dv/adc_ctrl_tb.sv */
// adc_ctrl_tb.sv: self-checking bench for the converter control block
// assumes the checker is bound in; settling is shortened to 3 cycles
`default_nettype none
`include "adc_ctrl_params.svh"
module adc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic ack_o, cmp_i, cmp_power_o, irq;
    logic [9:0] dac_o;
    logic [1:0] chan_sel_o;
    logic [39:0] vin = 40'h0;
    logic [7:0] radr [4] = '{`OFS_MODE, `OFS_CHAN, `OFS_MASK, 8'h1C};
    integer seed = 32'hdae2, fails = 0, checks = 0;
    always #20 clk_i = !clk_i;
    adc_ctrl #(.SETTLE_CYC(3)) u_adc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .cmp_i(cmp_i), .dac_o(dac_o),
        .chan_sel_o(chan_sel_o), .cmp_power_o(cmp_power_o), .conversion_end_irq_o(irq));
    analog_src u_analog_src (.clk_i(clk_i), .dac_i(dac_o), .chan_i(chan_sel_o),
        .power_i(cmp_power_o), .vin_i(vin), .cmp_o(cmp_i));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // entered just after a rising edge; leaves one idle cycle behind it
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 50);
        rd = dat_o;
        if (n >= 50) fails++;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wirq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 300)
        begin
            @(posedge clk_i);
            n++;
        end
        chk("irq", 1, irq);
    endtask
    task results;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial
    begin
        for (int i = 0; i < 4; i++)
            vin[i*10 +: 10] = 10'($random(seed));
        vin[39:20] = {10'h3FF, 10'h000};
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (radr[i])
        begin
            wb(0, radr[i], 0);
            chk("reset", 0, rd);
        end
        wb(1, `OFS_MASK, 3);
        wb(1, `OFS_MODE, 32'h80);
        wirq;
        wb(0, `OFS_STATUS, 0);
        chk("suspect", 3, rd);
        for (int c = 0; c < 4; c++)
        begin
            wb(1, `OFS_CHAN, c);
            wb(0, `OFS_STATUS, 0);
            chk("done kept", 1, rd[0]);
            wb(1, `OFS_STATUS, 3);
            wirq;
            wb(0, `OFS_RES_HIGH, 0);
            chk("res_high", {22'h0, vin[c*10 +: 10]}, rd);
            wb(0, `OFS_RES_LOW, 0);
            chk("res_low", {24'h0, vin[c*10 +: 8]}, rd);
            wb(0, `OFS_STATE, 0);
            chk("state", 32'(c * 4 + 2), rd);
        end
        wb(1, `OFS_MASK, 0);
        chk("masked", 0, irq);
        wb(1, `OFS_MODE, 1);
        chk("power", 1, cmp_power_o);
        wb(1, `OFS_STATUS, 3);
        wb(0, `OFS_STATE, 0);
        chk("waiting", 32'hD, rd);
        repeat (5) @(posedge clk_i);
        wb(1, `OFS_MASK, 1);
        wb(1, `OFS_MODE, 32'h81);
        wirq;
        wb(0, `OFS_STATUS, 0);
        chk("settled", 1, rd);
        wb(0, `OFS_RES_HIGH, 0);
        chk("res_high", 32'h3FF, rd);
        wb(1, `OFS_MODE, 0);
        chk("power", 0, cmp_power_o);
        // reset again in mid-run: flags and interrupt must come back clear
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(0, `OFS_STATUS, 0);
        chk("rst status", 0, rd);
        chk("rst irq", 0, irq);
        results;
    end
    initial
    begin
        #400000;
        fails++;
        results;
    end
endmodule // adc_ctrl_tb
`default_nettype wire

/* File: dv/analog_src.sv */
// analog_src.sv: four ideal analog sources feeding the converter's comparator
// assumes dac and channel select come straight from the control block
`default_nettype none
module analog_src (
    // clock
    input wire logic clk_i,
    // converter side
    input wire logic [9:0] dac_i,
    input wire logic [1:0] chan_i,
    input wire logic power_i,
    input wire logic [39:0] vin_i,
    output logic cmp_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic junk_r = 1'b0;
    // an unpowered comparator gives no answer, so it chatters instead
    always_ff @(posedge clk_i) junk_r <= !junk_r;
    assign cmp_o = power_i ? (vin_i[chan_i*10 +: 10] >= dac_i) : junk_r;
endmodule // analog_src
`default_nettype wire

/* File: hdl/adc_ctrl.sv */
// adc_ctrl.sv: four-channel converter control with wishbone registers
// assumes a classic wishbone master and a comparator fed by the analog front end
`default_nettype none
`include "adc_ctrl_params.svh"

// Behaviour
// [R1] channel rewrite never clears the conversion done flag
// [R2] a run ending as channel is rewritten may still post the old result; here the channel write discards it
// [R3] software clears the done flag before restarting conversion
// [R4] first result marked suspect if started early or with comparator off
// [R5] software waits for the end interrupt and drops the first result
// [R6] mode or channel writes may leave results undefined
// [R7] software reads the result before writing mode or channel
// [R8] start clear with comparator enabled puts converter in waiting state
// [R9] result read coinciding with update is served first, update follows
// [R10] mode or channel write at end of conversion suppresses update and irq
// [R11] end of conversion loads results, sets flag and raises irq
module adc_ctrl #(
    parameter int SETTLE_CYC = `SETTLE_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // analog front end
    input wire logic cmp_i,
    output logic [9:0] dac_o,
    output logic [1:0] chan_sel_o,
    output logic cmp_power_o,
    // interrupt
    output logic conversion_end_irq_o
);
    import adc_ctrl_pkg::*;

    // ----------------------------------------
    // registers and state
    // ----------------------------------------
    logic [7:0] converter_mode_reg_r, converter_mode_reg_nxt;
    logic [1:0] channel_select_reg_r, channel_select_reg_nxt;
    conv_result_t result_r, result_nxt;
    logic pend_r, pend_nxt;
    conv_result_t pend_res_r, pend_res_nxt;
    logic [1:0] status_r, status_nxt;
    logic [1:0] mask_r, mask_nxt;
    logic first_r, first_nxt;
    logic suspect_run_r, suspect_run_nxt;
    logic [15:0] settle_r, settle_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    conv_state_t state_r, state_nxt;

    logic req, wr, rd, wr_mode, wr_chan, rd_result, conv_done, restart;
    logic start_bit, cmp_en_bit, start_rise;
    logic [9:0] value;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    assign req = cyc_i && stb_i && !ack_r;
    assign wr = req && we_i && sel_i[0];
    assign rd = req && !we_i;
    assign wr_mode = wr && hit(adr_i, `OFS_MODE);
    assign wr_chan = wr && hit(adr_i, `OFS_CHAN);
    assign rd_result = rd && (hit(adr_i, `OFS_RES_LOW) || hit(adr_i, `OFS_RES_HIGH));
    assign start_bit = converter_mode_reg_r[`MODE_START_BIT];
    assign cmp_en_bit = converter_mode_reg_r[`MODE_CMP_EN_BIT];
    assign start_rise = wr_mode && dat_i[`MODE_START_BIT] && !start_bit;
    // a mode or channel write aborts the running step sequence
    assign restart = wr_mode || wr_chan;

    // ----------------------------------------
    // converter engine
    // ----------------------------------------
    sar_engine u_sar (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(state_r == ST_CONV),
        .restart_i(restart),
        .cmp_i(cmp_i),
        .dac_o(dac_o),
        .done_o(conv_done),
        .value_o(value)
    );

    // ----------------------------------------
    // control and result path
    // ----------------------------------------
    always_comb
    begin
        converter_mode_reg_nxt = converter_mode_reg_r;
        channel_select_reg_nxt = channel_select_reg_r;
        result_nxt = result_r;
        pend_nxt = pend_r;
        pend_res_nxt = pend_res_r;
        status_nxt = status_r;
        mask_nxt = mask_r;
        first_nxt = first_r;
        suspect_run_nxt = suspect_run_r;
        settle_nxt = settle_r;
        state_nxt = state_r;
        if (wr_mode)
            converter_mode_reg_nxt = dat_i[7:0];
        if (wr_chan)
            channel_select_reg_nxt = dat_i[1:0]; // [R1]
        if (wr && hit(adr_i, `OFS_MASK))
            mask_nxt = dat_i[1:0];
        if (wr && hit(adr_i, `OFS_STATUS))
            status_nxt = status_r & ~dat_i[1:0]; // [R3]
        // settle counter restarts whenever the comparator is switched on
        if (wr_mode && dat_i[`MODE_CMP_EN_BIT] && !cmp_en_bit)
            settle_nxt = 16'(SETTLE_CYC);
        else if (!cmp_en_bit)
            settle_nxt = 16'(SETTLE_CYC);
        else if (settle_r != 16'h0000)
            settle_nxt = settle_r - 16'h0001;
        if (start_rise)
        begin
            first_nxt = 1'b1;
            // a start before settling or with comparator off gives a poor first value
            suspect_run_nxt = !dat_i[`MODE_CMP_EN_BIT] || !cmp_en_bit
                || (settle_r != 16'h0000); // [R4]
        end
        // a held result lands once no read is in progress; a mode or channel write discards it
        if (pend_r && !rd_result && !restart)
        begin
            result_nxt = pend_res_r; // [R9]
            pend_nxt = 1'b0;
        end
        if (conv_done && !restart) // [R10]
        begin
            // the run that just ended used the current channel; a read in progress or a held result defers it
            if (rd_result || pend_r)
            begin
                pend_nxt = 1'b1; // [R9]
                pend_res_nxt = '{value: value, chan: channel_select_reg_r}; // [R2]
            end
            else
                result_nxt = '{value: value, chan: channel_select_reg_r}; // [R11]
            status_nxt[`ST_DONE_BIT] = 1'b1; // [R11]
            // sticky like the done bit: a later clean run must not wipe it
            status_nxt[`ST_SUSPECT_BIT] = status_nxt[`ST_SUSPECT_BIT]
                | (first_r && suspect_run_r); // [R4]
            first_nxt = 1'b0;
        end
        else if (conv_done)
            pend_nxt = 1'b0; // [R6]
        if (restart)
            pend_nxt = 1'b0; // [R6]
        case (state_r)
            ST_OFF, ST_WAIT, ST_CONV:
            begin
                if (converter_mode_reg_nxt[`MODE_START_BIT])
                    state_nxt = ST_CONV;
                else if (converter_mode_reg_nxt[`MODE_CMP_EN_BIT])
                    state_nxt = ST_WAIT; // [R8]
                else
                    state_nxt = ST_OFF;
            end
            default: state_nxt = ST_OFF;
        endcase
    end

    // ----------------------------------------
    // wishbone answer
    // ----------------------------------------
    always_comb
    begin
        ack_nxt = req;
        rdat_nxt = 32'h0000_0000;
        if (rd)
        begin
            case (adr_i)
                `OFS_MODE: rdat_nxt = {24'h000000, converter_mode_reg_r};
                `OFS_CHAN: rdat_nxt = {30'h0, channel_select_reg_r};
                `OFS_RES_LOW: rdat_nxt = {24'h000000, result_r.value[7:0]};
                `OFS_RES_HIGH: rdat_nxt = {22'h0, result_r.value};
                `OFS_STATUS: rdat_nxt = {30'h0, status_r};
                `OFS_MASK: rdat_nxt = {30'h0, mask_r};
                `OFS_STATE: rdat_nxt = {28'h0000000, result_r.chan, state_r};
                default: rdat_nxt = 32'h0000_0000;
            endcase
        end
        else if (!req)
            rdat_nxt = rdat_r;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            converter_mode_reg_r <= `MODE_RST;
            channel_select_reg_r <= `CHAN_RST;
            result_r <= '0;
            pend_r <= 1'b0;
            pend_res_r <= '0;
            status_r <= 2'h0;
            mask_r <= `MASK_RST;
            first_r <= 1'b0;
            suspect_run_r <= 1'b0;
            settle_r <= 16'(SETTLE_CYC);
            state_r <= ST_OFF;
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end
        else
        begin
            converter_mode_reg_r <= converter_mode_reg_nxt;
            channel_select_reg_r <= channel_select_reg_nxt;
            result_r <= result_nxt;
            pend_r <= pend_nxt;
            pend_res_r <= pend_res_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            first_r <= first_nxt;
            suspect_run_r <= suspect_run_nxt;
            settle_r <= settle_nxt;
            state_r <= state_nxt;
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    assign ack_o = ack_r;
    assign dat_o = rdat_r;
    assign chan_sel_o = channel_select_reg_r;
    assign cmp_power_o = (state_r != ST_OFF);
    assign conversion_end_irq_o = |(status_r & mask_r); // [R11]
endmodule // adc_ctrl
`default_nettype wire

/* File: hdl/adc_ctrl_params.svh */
// adc_ctrl_params.svh: offsets, field positions, reset values and timing counts
// assumes a 25 MHz clock and a 32-bit classic wishbone register bus
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_MODE 8'h00
`define OFS_CHAN 8'h04
`define OFS_RES_LOW 8'h08
`define OFS_RES_HIGH 8'h0C
`define OFS_STATUS 8'h10
`define OFS_MASK 8'h14
`define OFS_STATE 8'h18

// ----------------------------------------
// field positions
// ----------------------------------------
`define MODE_START_BIT 7
`define MODE_CMP_EN_BIT 0
`define ST_DONE_BIT 0
`define ST_SUSPECT_BIT 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define MODE_RST 8'h00
`define CHAN_RST 2'h0
`define MASK_RST 2'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 25
`define SETTLE_US 1
`define SETTLE_CYC (`SETTLE_US * `CLK_MHZ)
`define CONV_CYC 44

`endif

/* File: hdl/adc_ctrl_pkg.sv */
// adc_ctrl_pkg.sv: types shared by the converter control files
// assumes the params header is on the include path
`default_nettype none
package adc_ctrl_pkg;
    typedef enum logic [1:0] {ST_OFF, ST_WAIT, ST_CONV} conv_state_t;
    typedef struct packed {
        logic [9:0] value;
        logic [1:0] chan;
    } conv_result_t;
endpackage
`default_nettype wire

/* File: hdl/sar_engine.sv */
// sar_engine.sv: successive-approximation sequencer, one bit per step
// assumes the comparator answer is synchronous; restart aborts a run
`default_nettype none
`include "adc_ctrl_params.svh"
module sar_engine #(
    parameter int STEP_CYC = `CONV_CYC / 10
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic run_i,
    input wire logic restart_i,
    input wire logic cmp_i,
    // result
    output logic [9:0] dac_o,
    output logic done_o,
    output logic [9:0] value_o
);
    import adc_ctrl_pkg::*;

    logic [7:0] div_r, div_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [9:0] acc_r, acc_nxt;
    logic done_r, done_nxt;
    logic step;

    assign step = (div_r == 8'(STEP_CYC - 1));

    always_comb
    begin
        div_nxt = step ? 8'h00 : div_r + 8'h01;
        bit_nxt = bit_r;
        acc_nxt = acc_r;
        done_nxt = 1'b0;
        if (!run_i || restart_i)
        begin
            div_nxt = 8'h00;
            bit_nxt = 4'h9;
            acc_nxt = 10'h200;
        end
        else if (step)
        begin
            if (!cmp_i)
                acc_nxt[bit_r] = 1'b0;
            if (bit_r == 4'h0)
            begin
                done_nxt = 1'b1;
                bit_nxt = 4'h9;
            end
            else
            begin
                bit_nxt = bit_r - 4'h1;
                acc_nxt[bit_r - 4'h1] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div_r <= 8'h00;
            bit_r <= 4'h9;
            acc_r <= 10'h200;
            done_r <= 1'b0;
            value_o <= 10'h000;
        end
        else
        begin
            div_r <= div_nxt;
            bit_r <= bit_nxt;
            acc_r <= (done_nxt && bit_nxt == 4'h9) ? 10'h200 : acc_nxt;
            done_r <= done_nxt;
            if (done_nxt)
                value_o <= acc_nxt;
        end
    end

    assign dac_o = acc_r;
    assign done_o = done_r;
endmodule // sar_engine
`default_nettype wire
